// File: include/slcb_pkg.sv
/*
 * slcb_pkg: shared constants and types for the serial link capture buffer.
 * Assumes: a 125 MHz system clock; the link byte clock runs near 16 MHz.
 */
package slcb_pkg;
	// register byte addresses on the bus
	localparam int AXI_ADDR_W = 16;
	localparam logic [15:0] CSR_OFS = 16'h2000;
	localparam logic [15:0] ADDR_OFS = 16'h2004;
	localparam logic [15:0] IRQ_STAT_OFS = 16'h2008;
	localparam logic [15:0] IRQ_MASK_OFS = 16'h200c;
	localparam logic [2:0] BUF_SEL = 3'h0; // address bits 15:13 select the buffer
	// control/status field positions
	localparam int CSR_REALIGN = 0;
	localparam int CSR_SELFTEST = 1;
	localparam int CSR_SWRESET = 2;
	localparam int CSR_STREAM = 4;
	localparam int CSR_EXPIRY = 5;
	localparam int CSR_EXP_STREAM = 6;
	localparam int CSR_EXP_SELFTEST = 7;
	localparam int CSR_VIO_STREAM = 8;
	localparam int CSR_VIO_SELFTEST = 9;
	localparam int CSR_OVERFLOW = 10;
	// interrupt status and mask field positions
	localparam int IRQ_EXPIRY = 0;
	localparam int IRQ_VIOLATION = 1;
	localparam int IRQ_STREAM_END = 2;
	localparam int IRQ_OVERFLOW = 3;
	localparam int IRQ_W = 4;
	// reset values
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	// special characters (data byte with the special flag high)
	localparam logic [7:0] CHAR_START = 8'h00; // K28.0
	localparam logic [7:0] CHAR_STOP = 8'h08; // K23.7
	// expiry: counts link byte clocks
	localparam int LINK_RATE_KHZ = 16000;
	localparam int EXPIRY_TIME_MS = 4;
	localparam int EXPIRY_LINK_TICKS = LINK_RATE_KHZ * EXPIRY_TIME_MS;
	localparam int EXPIRY_W = 16;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one decoded symbol from the deserializer
	typedef struct packed {
		logic violation;
		logic special;
		logic [7:0] data;
	} slcb_link_byte_type;

	// every pin that arrives from the deserializer or the crate
	typedef struct packed {
		logic masterClear;
		logic byteClock;
		logic readyN;
		slcb_link_byte_type sym;
	} slcb_link_pins_type;
endpackage : slcb_pkg

// File: design/slcb_pin_sync.sv
/*
 * slcb_pin_sync: two-flop synchroniser for a bundle of pins.
 * Assumes: each bit is a slow level or is sampled with a skew-tolerant scheme.
 */
`timescale 1ns/1ps
module slcb_pin_sync #(
	parameter int WIDTH = 1
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1_r; // read by the second stage only

	// both stages clear on reset; metastability settles in stage1
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage1_r <= '0;
			dout <= '0;
		end else begin
			stage1_r <= din;
			dout <= stage1_r;
		end
	end
endmodule : slcb_pin_sync

// File: design/slcb_dual_buffer.sv
/*
 * slcb_dual_buffer: event buffer as four byte-wide banks, two write sides.
 * Assumes: link side writes single bytes; bus side writes by byte strobes.
 */
`timescale 1ns/1ps
module slcb_dual_buffer #(
	parameter int ADDR_W = 11
)(
	input wire logic clk,
	input wire logic linkWe,
	input wire logic [ADDR_W-1:0] linkAddr,
	input wire logic [1:0] linkLane,
	input wire logic [7:0] linkData,
	input wire logic busWe,
	input wire logic [ADDR_W-1:0] busAddr,
	input wire logic [3:0] busStrb,
	input wire logic [31:0] busData,
	input wire logic [ADDR_W-1:0] rdAddr,
	output logic [31:0] rdData
);
	localparam int DEPTH = 1 << ADDR_W;

	// one bank per byte, each with its own writer process; the link wins a lane both sides hit at once
	for (genvar lane = 0; lane < 4; lane++) begin : gBank
		logic [7:0] bank [DEPTH]; // one byte-wide store
		wire linkHit = linkWe && (linkLane == 2'(lane));
		wire busHit = busWe && busStrb[lane];
		// read port serves the bus only; the link side never reads
		assign rdData[lane*8 +: 8] = bank[rdAddr];
		always_ff @(posedge clk) begin
			if (linkHit) begin
				bank[linkAddr] <= linkData;
			end else if (busHit) begin
				bank[busAddr] <= busData[lane*8 +: 8];
			end
		end
	end
endmodule : slcb_dual_buffer

// File: design/slcb_capture_top.sv
/*
 * slcb_capture_top: receive control for one link channel: stream framing,
 * expiry timing, violation and overflow flags, buffer fill and bus slave.
 * Assumes: deserializer pins and the master clear arrive asynchronously;
 * the byte clock is far slower than clk, so it is sampled and edge-found.
 */
`timescale 1ns/1ps
module slcb_capture_top
	import slcb_pkg::*;
#(
	parameter int ADDR_W = 11, // buffer word address bits
	parameter int EXPIRY_TICKS = EXPIRY_LINK_TICKS, // byte clocks to expiry
	parameter logic [7:0] END_CHAR = 8'h7b // end-of-transfer code, value arbitrary
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic recoveredByteClock,
	input wire logic byteReadyN,
	input wire logic [7:0] byteData,
	input wire logic specialChar,
	input wire logic codeViolation,
	input wire logic masterClear,
	output logic realignEnable,
	output logic selfTestEnableN,
	output logic irq,
	input wire logic [AXI_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [AXI_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	localparam int CNT_W = ADDR_W + 3; // byte lane + word + top bit
	localparam int TOP = CNT_W - 1;
	localparam logic [EXPIRY_W-1:0] EXPIRY_LAST = EXPIRY_W'(EXPIRY_TICKS - 1);

	// ---------------- pin capture ----------------
	slcb_link_pins_type pinsRaw; // straight from the pins
	slcb_link_pins_type pins; // after two flops
	logic [$bits(slcb_link_pins_type)-1:0] pinsSyncBits;
	logic byteClkPrev_r; // previous synced byte clock

	assign pinsRaw = '{masterClear: masterClear, byteClock: recoveredByteClock, readyN: byteReadyN,
		sym: '{violation: codeViolation, special: specialChar, data: byteData}};

	// data and strobe share the clock's delay, so they stay aligned
	slcb_pin_sync #(
		.WIDTH($bits(slcb_link_pins_type))
	) uPinSync (
		.clk(clk),
		.rst_n(rst_n),
		.din(pinsRaw),
		.dout(pinsSyncBits)
	);
	assign pins = pinsSyncBits;

	// edge finder on the synced byte clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			byteClkPrev_r <= 1'b0;
		end else begin
			byteClkPrev_r <= pins.byteClock;
		end
	end

	// ---------------- control state ----------------
	logic realignRequest_r; // software: let the deserializer realign
	logic selfTest_r; // software: self test in progress
	logic selfTestPrev_r; // for the falling edge of self test
	logic swResetPulse_r; // one-cycle software reset
	logic streamActiveFlag_r; // data transfer in progress
	logic [EXPIRY_W-1:0] expiryCnt_r; // byte clocks since last clear
	logic expiryFlag_r;
	logic streamExpiryFlag_r;
	logic selftestExpiryFlag_r;
	logic streamViolationFlag_r;
	logic selftestViolationFlag_r;
	logic streamOverflowFlag_r;
	logic [CNT_W-1:0] addrCnt_r; // byte address into the buffer
	logic selfTestN_r; // drives the active-low test pin
	logic [IRQ_W-1:0] irqStat_r;
	logic [IRQ_W-1:0] irqMask_r;
	logic irq_r;

	// decoded link events
	wire byteClkRise = pins.byteClock & ~byteClkPrev_r;
	wire newByte = byteClkRise & ~pins.readyN;
	wire specialSeen = newByte & pins.sym.special;
	wire isStart = specialSeen & (pins.sym.data == CHAR_START);
	wire isStop = specialSeen & (pins.sym.data == CHAR_STOP);
	wire isEnd = specialSeen & (pins.sym.data == END_CHAR);
	wire clearAll = swResetPulse_r | pins.masterClear;
	wire selfTestFall = selfTestPrev_r & ~selfTest_r;
	wire timedOp = streamActiveFlag_r | selfTest_r;
	wire expiryHit = byteClkRise & timedOp & ~expiryFlag_r & (expiryCnt_r == EXPIRY_LAST);
	wire cntClear = clearAll | (isEnd & ~streamActiveFlag_r) | selfTestFall;
	wire addrCounterTopBit = addrCnt_r[TOP];
	// only data bytes are stored; the framing characters are not
	wire bufferWriteStrobe = newByte & ~pins.sym.special & streamActiveFlag_r & realignRequest_r
		& ~selfTest_r & ~addrCounterTopBit;
	wire [1:0] linkLane = {~addrCnt_r[1], addrCnt_r[0]};
	wire violStream = newByte & pins.sym.violation & streamActiveFlag_r;
	wire violTest = newByte & pins.sym.violation & selfTest_r;

	// expiry counter: clear wins over counting; it parks once expired
	always_ff @(posedge clk) begin
		if (!rst_n || cntClear) begin
			expiryCnt_r <= '0;
		end else if (byteClkRise && timedOp && !expiryFlag_r) begin
			expiryCnt_r <= expiryCnt_r + 1'b1;
		end
	end

	// stream flag: reset and stop clear it, start char sets it
	always_ff @(posedge clk) begin
		if (!rst_n || clearAll || isStop || expiryHit) begin
			streamActiveFlag_r <= 1'b0;
		end else if (isStart) begin
			streamActiveFlag_r <= 1'b1;
		end
	end

	// sticky error flags; a set in the clearing cycle still lands
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			expiryFlag_r <= 1'b0;
			streamExpiryFlag_r <= 1'b0;
			selftestExpiryFlag_r <= 1'b0;
			streamViolationFlag_r <= 1'b0;
			selftestViolationFlag_r <= 1'b0;
			streamOverflowFlag_r <= 1'b0;
		end else begin
			expiryFlag_r <= expiryHit | (expiryFlag_r & ~clearAll);
			streamExpiryFlag_r <= (expiryHit & streamActiveFlag_r) | (streamExpiryFlag_r & ~clearAll);
			selftestExpiryFlag_r <= (expiryHit & selfTest_r) | (selftestExpiryFlag_r & ~clearAll);
			streamViolationFlag_r <= violStream | (streamViolationFlag_r & ~clearAll);
			selftestViolationFlag_r <= violTest | (selftestViolationFlag_r & ~clearAll);
			streamOverflowFlag_r <= addrCounterTopBit | (streamOverflowFlag_r & ~clearAll);
		end
	end

	// buffer address: restarts with each event, frozen at the top bit
	always_ff @(posedge clk) begin
		if (!rst_n || clearAll || isStart) begin
			addrCnt_r <= '0;
		end else if (bufferWriteStrobe) begin
			addrCnt_r <= addrCnt_r + 1'b1;
		end
	end

	// ---------------- bus slave ----------------
	logic awHave_r;
	logic wHave_r;
	logic [AXI_ADDR_W-1:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic [31:0] bufRdWord;

	wire doWrite = awHave_r & wHave_r & ~bvalid;
	wire wrIsBuf = awAddr_r[15:13] == BUF_SEL;
	wire wrIsCsr = awAddr_r[15:2] == CSR_OFS[15:2];
	wire wrIsStat = awAddr_r[15:2] == IRQ_STAT_OFS[15:2];
	wire wrIsMask = awAddr_r[15:2] == IRQ_MASK_OFS[15:2];
	wire wrIsAddr = awAddr_r[15:2] == ADDR_OFS[15:2];
	wire wrHit = wrIsBuf | wrIsCsr | wrIsStat | wrIsMask | wrIsAddr;
	wire csrWr = doWrite & wrIsCsr & wStrb_r[0];
	wire statWr = doWrite & wrIsStat & wStrb_r[0];
	wire maskWr = doWrite & wrIsMask & wStrb_r[0];
	// bus lanes run byte-reversed against the banks
	wire [31:0] wDataSwap = {wData_r[7:0], wData_r[15:8], wData_r[23:16], wData_r[31:24]};
	wire [3:0] wStrbSwap = {wStrb_r[0], wStrb_r[1], wStrb_r[2], wStrb_r[3]};
	wire rdIsBuf = araddr[15:13] == BUF_SEL;
	wire rdIsCsr = araddr[15:2] == CSR_OFS[15:2];
	wire rdIsAddr = araddr[15:2] == ADDR_OFS[15:2];
	wire rdIsStat = araddr[15:2] == IRQ_STAT_OFS[15:2];
	wire rdIsMask = araddr[15:2] == IRQ_MASK_OFS[15:2];
	wire rdHit = rdIsBuf | rdIsCsr | rdIsAddr | rdIsStat | rdIsMask;
	wire [31:0] bufRdSwap = {bufRdWord[7:0], bufRdWord[15:8], bufRdWord[23:16], bufRdWord[31:24]};
	wire [31:0] csrView = 32'(
		(32'(realignRequest_r) << CSR_REALIGN) | (32'(selfTest_r) << CSR_SELFTEST)
		| (32'(streamActiveFlag_r) << CSR_STREAM) | (32'(expiryFlag_r) << CSR_EXPIRY)
		| (32'(streamExpiryFlag_r) << CSR_EXP_STREAM) | (32'(selftestExpiryFlag_r) << CSR_EXP_SELFTEST)
		| (32'(streamViolationFlag_r) << CSR_VIO_STREAM)
		| (32'(selftestViolationFlag_r) << CSR_VIO_SELFTEST)
		| (32'(streamOverflowFlag_r) << CSR_OVERFLOW));
	wire [31:0] rdMux = rdIsBuf ? bufRdSwap : rdIsCsr ? csrView : rdIsAddr ? 32'(addrCnt_r)
		: rdIsStat ? 32'(irqStat_r) : rdIsMask ? 32'(irqMask_r) : RDATA_RESET;

	// four byte banks with two write sides: link side by lane, bus side by strobes
	slcb_dual_buffer #(
		.ADDR_W(ADDR_W)
	) uBuffer (
		.clk(clk),
		.linkWe(bufferWriteStrobe),
		.linkAddr(addrCnt_r[ADDR_W+1:2]),
		.linkLane(linkLane),
		.linkData(pins.sym.data),
		.busWe(doWrite & wrIsBuf),
		.busAddr(awAddr_r[ADDR_W+1:2]),
		.busStrb(wStrbSwap),
		.busData(wDataSwap),
		.rdAddr(araddr[ADDR_W+1:2]),
		.rdData(bufRdWord)
	);

	// write channels: address and data taken in either order
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			awAddr_r <= '0;
			wData_r <= '0;
			wStrb_r <= '0;
		end else if (doWrite) begin
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
		end else begin
			if (awvalid && awready) begin
				awHave_r <= 1'b1;
				awready <= 1'b0;
				awAddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				wHave_r <= 1'b1;
				wready <= 1'b0;
				wData_r <= wdata;
				wStrb_r <= wstrb;
			end
		end
	end

	// write response one cycle after both halves are held
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// read: data one cycle after the address is taken
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= RDATA_RESET;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rdMux;
			rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
		end
	end

	// control bits; the software reset bit reads back as zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			realignRequest_r <= 1'b0;
			selfTest_r <= 1'b0;
			selfTestPrev_r <= 1'b0;
			swResetPulse_r <= 1'b0;
			selfTestN_r <= 1'b1;
		end else begin
			selfTestPrev_r <= selfTest_r;
			selfTestN_r <= ~selfTest_r;
			swResetPulse_r <= csrWr & wData_r[CSR_SWRESET];
			if (csrWr) begin
				realignRequest_r <= wData_r[CSR_REALIGN];
				selfTest_r <= wData_r[CSR_SELFTEST];
			end
		end
	end

	// ---------------- interrupts ----------------
	wire [IRQ_W-1:0] irqEvents = IRQ_W'((32'(expiryHit) << IRQ_EXPIRY)
		| (32'(violStream | violTest) << IRQ_VIOLATION) | (32'(isStop) << IRQ_STREAM_END)
		| (32'(addrCounterTopBit & ~streamOverflowFlag_r) << IRQ_OVERFLOW));
	wire [IRQ_W-1:0] irqClr = statWr ? wData_r[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0] irqStatNxt = irqEvents | (irqStat_r & ~irqClr);

	// write-one-to-clear status; a new event beats the clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irqStat_r <= '0;
			irqMask_r <= IRQ_MASK_RESET;
			irq_r <= 1'b0;
		end else begin
			irqStat_r <= irqStatNxt;
			irq_r <= |(irqStatNxt & (maskWr ? wData_r[IRQ_W-1:0] : irqMask_r));
			if (maskWr) begin
				irqMask_r <= wData_r[IRQ_W-1:0];
			end
		end
	end

	assign irq = irq_r;
	assign realignEnable = realignRequest_r;
	assign selfTestEnableN = selfTestN_r;

	// ---------------- checks ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence sExpire;
		expiryHit && streamActiveFlag_r;
	endsequence
	sequence sDataByte;
		bufferWriteStrobe && !clearAll && !isStart;
	endsequence

	AST_EXPIRY_SET: assert property (expiryHit |=> expiryFlag_r && !streamActiveFlag_r)
		else $error("expiry did not set flag");
	AST_EXPIRY_SOURCE: assert property (sExpire |=> streamExpiryFlag_r)
		else $error("stream expiry source bit missing");
	AST_CNT_CLEAR: assert property (clearAll |=> expiryCnt_r == '0)
		else $error("expiry counter not cleared");
	AST_CNT_IDLE: assert property (!timedOp && !cntClear |=> $stable(expiryCnt_r))
		else $error("expiry counter moved while idle");
	AST_VIOLATION: assert property (violStream |=> streamViolationFlag_r)
		else $error("stream violation not flagged");
	AST_STREAM_START: assert property (isStart && !clearAll && !expiryHit |=> streamActiveFlag_r)
		else $error("start char did not open stream");
	AST_STREAM_STOP: assert property (isStop |=> !streamActiveFlag_r)
		else $error("stop char did not close stream");
	AST_ADDR_STEP: assert property (sDataByte |=> addrCnt_r == $past(addrCnt_r) + 1'b1)
		else $error("address did not step on data byte");
	AST_OVF_HOLD: assert property (addrCounterTopBit && !clearAll && !isStart
		|=> $stable(addrCnt_r) && streamOverflowFlag_r)
		else $error("overflow did not block counting");
	AST_STICKY: assert property (expiryFlag_r && !clearAll |=> expiryFlag_r [*2] or clearAll)
		else $error("expiry flag dropped without reset");
endmodule : slcb_capture_top

// File: sim/slcb_link_model.sv
/*
 * slcb_link_model: behavioural deserializer on the far side of the link pins.
 * Assumes: the bench calls send once per symbol; the byte clock parks low between calls.
 */
`timescale 1ns/1ps
module slcb_link_model (
	input wire logic realignEnable,
	output logic recoveredByteClock,
	output logic byteReadyN,
	output logic [7:0] byteData,
	output logic specialChar,
	output logic codeViolation
);
	// idle lines: clock still, no byte offered
	initial begin
		recoveredByteClock = 1'b0;
		byteReadyN = 1'b1;
		byteData = 8'h00;
		specialChar = 1'b0;
		codeViolation = 1'b0;
	end
	// framing never slips here, so realignEnable cannot move byte boundaries
	// one symbol per 125 ns byte period; a pad symbol leaves ready high
	task automatic send(input logic [7:0] d, input logic sc, input logic rv, input logic pad);
		byteReadyN = pad;
		byteData = d;
		specialChar = sc;
		codeViolation = rv;
		#31.25 recoveredByteClock = 1'b1;
		#62.5 recoveredByteClock = 1'b0;
		// hold has run out: turn the lines over so a stale value never passes
		byteReadyN = 1'b1;
		byteData = ~d;
		specialChar = ~sc;
		codeViolation = ~rv;
		#31.25;
	endtask : send
endmodule : slcb_link_model

// File: sim/testbench.sv
/*
 * testbench: self-checking bench for slcb_capture_top with a short expiry and buffer.
 * Assumes: slcb_link_model plays the deserializer; the bus tasks act as AXI4-Lite master.
 */
`timescale 1ns/1ps
module testbench import slcb_pkg::*; ;
	localparam logic [31:0] ALL = 32'hffff_ffff; // compare every bit
	localparam logic [7:0] END_CODE = 8'h7b; // end-of-transfer code handed to the design, value arbitrary
	logic clk, rst_n, masterClear, awvalid, wvalid, bready, arvalid, rready;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic awready, wready, bvalid, arready, rvalid, irq, realignEnable, selfTestEnableN;
	logic recoveredByteClock, byteReadyN, specialChar, codeViolation;
	logic [7:0] byteData;
	int fails = 0;
	int checked = 0;
	int cyc = 0;

	// far side of the link
	slcb_link_model link (.realignEnable(realignEnable), .recoveredByteClock(recoveredByteClock),
		.byteReadyN(byteReadyN), .byteData(byteData), .specialChar(specialChar),
		.codeViolation(codeViolation));
	// small buffer and expiry keep overflow and timeout reachable in a short run
	slcb_capture_top #(.ADDR_W(2), .EXPIRY_TICKS(20), .END_CHAR(END_CODE)) dut (.clk(clk), .rst_n(rst_n),
		.recoveredByteClock(recoveredByteClock), .byteReadyN(byteReadyN), .byteData(byteData),
		.specialChar(specialChar), .codeViolation(codeViolation), .masterClear(masterClear),
		.realignEnable(realignEnable), .selfTestEnableN(selfTestEnableN), .irq(irq),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	task automatic end_sim;
		if (fails == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// each channel is released right after the rising edge that finds its valid and ready both high
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic ta, tw, done;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(posedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			done = bvalid && bready;
			r = bresp;
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (done) bready <= 1'b0;
		end
	endtask : wr

	task automatic rdb(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, done;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(posedge clk);
			ta = arvalid && arready;
			done = rvalid && rready;
			d = rdata;
			r = rresp;
			if (ta) arvalid <= 1'b0;
			if (done) rready <= 1'b0;
		end
	endtask : rdb

	// read a word and compare the bits under a mask
	task automatic rdchk(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rdb(a, d, r);
		chk(d & m, e);
	endtask : rdchk

	// lets a link symbol cross the pin synchronisers and land
	task automatic settle;
		repeat (8) @(posedge clk);
	endtask : settle

	task automatic t_reset;
		chk({29'h0, realignEnable, selfTestEnableN, irq}, 32'h2);
		rdchk(CSR_OFS, ALL, 32'h0);
		rdchk(IRQ_MASK_OFS, ALL, 32'h0);
		rdchk(IRQ_STAT_OFS, ALL, 32'h0);
		rdb(16'h3000, rd, rs);
		chk({rd[29:0], rs}, {30'h0, RESP_SLVERR});
		wr(16'h3000, 32'h1, 4'hf, rs);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
	endtask : t_reset

	// start, two words with a pad between, stop; then bus-side lane writes
	task automatic t_capture;
		// with realign still low a data byte must not be stored
		link.send(CHAR_START, 1'b1, 1'b0, 1'b0);
		link.send(8'h99, 1'b0, 1'b0, 1'b0);
		settle;
		rdchk(ADDR_OFS, ALL, 32'h0);
		wr(CSR_OFS, 32'h1, 4'hf, rs);
		chk({31'h0, realignEnable}, 32'h1);
		link.send(CHAR_START, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			if (i == 4) link.send(8'hee, 1'b0, 1'b0, 1'b1);
			link.send(8'ha0 + 8'(i), 1'b0, 1'b0, 1'b0);
		end
		settle;
		rdchk(CSR_OFS, ALL, 32'h11);
		link.send(CHAR_STOP, 1'b1, 1'b0, 1'b0);
		settle;
		rdchk(CSR_OFS, ALL, 32'h1);
		rdchk(ADDR_OFS, ALL, 32'h8);
		rdchk(16'h0000, ALL, 32'ha2a3a0a1);
		rdchk(16'h0004, ALL, 32'ha6a7a4a5);
		rdchk(IRQ_STAT_OFS, ALL, 32'h4);
		wr(IRQ_STAT_OFS, 32'h4, 4'hf, rs);
		rdchk(IRQ_STAT_OFS, ALL, 32'h0);
		wr(16'h000c, 32'h1122_3344, 4'hf, rs);
		wr(16'h000c, 32'h0000_00aa, 4'h1, rs);
		rdchk(16'h000c, ALL, 32'h1122_33aa);
		wr(ADDR_OFS, 32'h0, 4'hf, rs);
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
		rdchk(ADDR_OFS, ALL, 32'h8);
	endtask : t_capture

	// violation sets a sticky flag and the interrupt; master clear removes it
	task automatic t_violation;
		wr(IRQ_MASK_OFS, 32'h2, 4'hf, rs);
		link.send(CHAR_START, 1'b1, 1'b0, 1'b0);
		link.send(8'h5c, 1'b0, 1'b1, 1'b0);
		link.send(CHAR_STOP, 1'b1, 1'b0, 1'b0);
		settle;
		rdchk(CSR_OFS, ALL, 32'h101);
		chk({31'h0, irq}, 32'h1);
		wr(IRQ_STAT_OFS, 32'h6, 4'hf, rs);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rdchk(CSR_OFS, ALL, 32'h101);
		masterClear <= 1'b1;
		repeat (4) @(posedge clk);
		masterClear <= 1'b0;
		settle;
		rdchk(CSR_OFS, 32'h7f0, 32'h0);
	endtask : t_violation

	// stream expiry just short of and past the count; self-test expiry past it only
	task automatic t_expiry;
		wr(IRQ_MASK_OFS, 32'h1, 4'hf, rs);
		link.send(CHAR_START, 1'b1, 1'b0, 1'b0);
		repeat (18) link.send(8'h33, 1'b0, 1'b0, 1'b1);
		settle;
		rdchk(CSR_OFS, ALL, 32'h11);
		repeat (3) link.send(8'h33, 1'b0, 1'b0, 1'b1);
		settle;
		rdchk(CSR_OFS, ALL, 32'h61);
		chk({31'h0, irq}, 32'h1);
		wr(CSR_OFS, 32'h5, 4'hf, rs);
		rdchk(CSR_OFS, ALL, 32'h1);
		wr(IRQ_STAT_OFS, 32'h1, 4'hf, rs);
		wr(CSR_OFS, 32'h3, 4'hf, rs);
		repeat (2) @(posedge clk);
		chk({31'h0, selfTestEnableN}, 32'h0);
		link.send(8'h33, 1'b0, 1'b1, 1'b0);
		repeat (21) link.send(8'h33, 1'b0, 1'b0, 1'b1);
		settle;
		rdchk(CSR_OFS, ALL, 32'h2a3);
		wr(CSR_OFS, 32'h1, 4'hf, rs);
		repeat (2) @(posedge clk);
		chk({31'h0, selfTestEnableN}, 32'h1);
		wr(CSR_OFS, 32'h5, 4'hf, rs);
		rdchk(CSR_OFS, ALL, 32'h1);
	endtask : t_expiry

	// seventeen bytes into a sixteen-byte buffer: the last must not wrap
	task automatic t_overflow;
		link.send(CHAR_START, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 17; i++) link.send(8'h40 + 8'(i), 1'b0, 1'b0, 1'b0);
		settle;
		rdchk(ADDR_OFS, ALL, 32'h10);
		rdchk(CSR_OFS, 32'h400, 32'h400);
		rdchk(16'h0000, ALL, 32'h4243_4041);
		rdchk(IRQ_STAT_OFS, 32'h8, 32'h8);
		// end code after the stop clears the expiry count, so 18 more ticks stay short of expiry
		link.send(CHAR_STOP, 1'b1, 1'b0, 1'b0);
		link.send(END_CODE, 1'b1, 1'b0, 1'b0);
		link.send(CHAR_START, 1'b1, 1'b0, 1'b0);
		repeat (18) link.send(8'h33, 1'b0, 1'b0, 1'b1);
		settle;
		rdchk(CSR_OFS, 32'h30, 32'h10);
	endtask : t_overflow

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// cuts a hang short; the whole sequence needs under two thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			end_sim;
		end
	end

	initial begin
		rst_n = 1'b0;
		masterClear = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata, wstrb} = 68'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset;
		t_capture;
		t_violation;
		t_expiry;
		t_overflow;
		end_sim;
	end
endmodule : testbench
